// [core/csfh_consts.svh]
// Purpose: Named constants for the codec status/filter/headset register bank
// Assumes: Byte-wide registers on a plain strobe port
// Notes:   Offsets, fields, reset values and timing figures live here
`ifndef CSFH_CONSTS_SVH
`define CSFH_CONSTS_SVH

// ==========================================================
// Register offsets
`define CSFH_OFS_OVF_PLL     8'h0b
`define CSFH_OFS_FILT        8'h0c
`define CSFH_OFS_HSDET       8'h0d
`define CSFH_OFS_BTN         8'h0e
`define CSFH_OFS_IRQ_STAT    8'h10
`define CSFH_OFS_IRQ_MASK    8'h11

// ==========================================================
// Reset values
`define CSFH_RST_PLL         4'h1
`define CSFH_RST_FILT        8'h00
`define CSFH_RST_HSDET_EN    1'b0
`define CSFH_RST_JACK_DB     3'h0
`define CSFH_RST_BTN_DB      2'h0

// ==========================================================
// Field positions
`define CSFH_BIT_OVF_ADC_L   7
`define CSFH_BIT_OVF_ADC_R   6
`define CSFH_BIT_OVF_DAC_L   5
`define CSFH_BIT_OVF_DAC_R   4
`define CSFH_BIT_HS_EN       7
`define CSFH_BIT_BTN_FLAG    5
`define CSFH_BIT_HS_FLAG     4
`define CSFH_PLL_HI          3
`define CSFH_JACK_HI         4
`define CSFH_JACK_LO         2
`define CSFH_BTN_HI          1

// ==========================================================
// Timing
`define CSFH_MS_NS           1000000
`define CSFH_CLK_NS          10
`define CSFH_MS_CYCLES       (`CSFH_MS_NS / `CSFH_CLK_NS)
`define CSFH_JACK_BASE_MS    2
`define CSFH_BTN_BASE_MS     1
`define CSFH_DB_SAMPLES      8
`define CSFH_HS_NONE         2'h0

`endif

// [core/csfh_pkg.sv]
// Purpose: Types for the codec status/filter/headset register bank
// Assumes: Constants come from csfh_consts.svh
// Notes:   Types only
package csfh_pkg;
	typedef logic [1:0] csfh_hpf_t;
	typedef logic [2:0] csfh_jack_db_t;
	typedef logic [1:0] csfh_btn_db_t;
endpackage

// [core/csfh_regs.sv]
// Purpose: Overflow flags, PLL divider, filter controls, headset detection regs
// Assumes: Detector and saturation inputs are asynchronous to clk_sys
// Notes:   Sticky flags clear only on the bits returned as one
// Operation
// - Left ADC overflow bit D7 latches high and holds.
// - Right ADC overflow bit D6 latches high and holds.
// - Left and right DAC overflow bits D5, D4 latch and hold.
// - Overflow bits clear when their register is read; reset to zero.
// - PLL divider nibble resets to 0001; code 0000 means divide by 16.
// - Left ADC highpass select D7-D6; 00 disables, others pick corners.
// - Right ADC highpass select D5-D4 uses the same encoding.
// - D3 and D1 enable left and right DAC effects filters.
// - D2 and D0 enable left and right de-emphasis; all reset zero.
// - Headset detection enable D7, writable, resets to zero.
// - Headset type reads 00 none, 01 no mic, 11 with mic.
// - Jack debounce 16 ms on 2 ms tick, doubling per code to 512 ms at code 5; codes 6 and 7 give 1024 ms.
// - Button debounce none, 8, 16, 32 ms on 1, 2, 4 ms ticks.
// - Button press flag latches high and clears on read.
`timescale 1ns/10ps
`default_nettype none
`include "csfh_consts.svh"

module csfh_regs #(
	parameter int MS_CYCLES = `CSFH_MS_CYCLES
) (
	input  wire logic       clk_sys,
	input  wire logic       rstn,
	input  wire logic       clk_en,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	input  wire logic       sat_adc_l,
	input  wire logic       sat_adc_r,
	input  wire logic       sat_dac_l,
	input  wire logic       sat_dac_r,
	input  wire logic       jack_in,
	input  wire logic       jack_mic,
	input  wire logic       button_in,
	output logic      [3:0] pll_div,
	output logic      [4:0] pll_ratio,
	output logic      [1:0] hpf_sel_l,
	output logic      [1:0] hpf_sel_r,
	output logic            eff_en_l,
	output logic            deemph_en_l,
	output logic            eff_en_r,
	output logic            deemph_en_r,
	output logic            hsdet_en,
	output logic            irq
);

	// ==========================================================
	// Input synchronisers: async pins pass two flops
	logic [6:0] sync1_r;
	logic [6:0] sync2_r;
	logic [6:0] sync1_nxt;
	logic [6:0] sync2_nxt;

	always_comb
	begin
		sync1_nxt = {button_in, jack_mic, jack_in, sat_dac_r, sat_dac_l, sat_adc_r, sat_adc_l};
		sync2_nxt = sync1_r;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			sync1_r <= 7'h00;
			sync2_r <= 7'h00;
		end
		else if (clk_en)
		begin
			sync1_r <= sync1_nxt;
			sync2_r <= sync2_nxt;
		end
	end

	// ==========================================================
	// Millisecond time base and tick prescaler
	localparam int MSW = $clog2(MS_CYCLES);
	logic [MSW-1:0] ms_cnt_r;
	logic [MSW-1:0] ms_cnt_nxt;
	logic [6:0]     ms_free_r;
	logic [6:0]     ms_free_nxt;
	logic           ms_tick;

	// Free-running so debounce phase does not depend on writes
	always_comb
	begin
		ms_tick = (ms_cnt_r == MSW'(MS_CYCLES - 1));
		ms_cnt_nxt = ms_tick ? '0 : ms_cnt_r + 1'b1;
		ms_free_nxt = ms_tick ? ms_free_r + 7'h01 : ms_free_r;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			ms_cnt_r  <= '0;
			ms_free_r <= 7'h00;
		end
		else if (clk_en)
		begin
			ms_cnt_r  <= ms_cnt_nxt;
			ms_free_r <= ms_free_nxt;
		end
	end

	// ==========================================================
	// Control registers
	logic [3:0]               pll_r, pll_nxt;
	logic [7:0]               filt_r, filt_nxt;
	logic                     hs_en_r, hs_en_nxt;
	csfh_pkg::csfh_jack_db_t  jack_db_r, jack_db_nxt;
	csfh_pkg::csfh_btn_db_t   btn_db_r, btn_db_nxt;
	logic [4:0]               mask_r, mask_nxt;

	always_comb
	begin
		pll_nxt = pll_r;
		filt_nxt = filt_r;
		hs_en_nxt = hs_en_r;
		jack_db_nxt = jack_db_r;
		btn_db_nxt = btn_db_r;
		mask_nxt = mask_r;
		if (reg_wr)
		begin
			unique case (reg_addr)
				`CSFH_OFS_OVF_PLL: pll_nxt = reg_wdata[`CSFH_PLL_HI:0];
				`CSFH_OFS_FILT:    filt_nxt = reg_wdata;
				`CSFH_OFS_HSDET:
				begin
					hs_en_nxt = reg_wdata[`CSFH_BIT_HS_EN];
					jack_db_nxt = reg_wdata[`CSFH_JACK_HI:`CSFH_JACK_LO];
					btn_db_nxt = reg_wdata[`CSFH_BTN_HI:0];
				end
				`CSFH_OFS_IRQ_MASK: mask_nxt = reg_wdata[4:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			pll_r     <= `CSFH_RST_PLL;
			filt_r    <= `CSFH_RST_FILT;
			hs_en_r   <= `CSFH_RST_HSDET_EN;
			jack_db_r <= `CSFH_RST_JACK_DB;
			btn_db_r  <= `CSFH_RST_BTN_DB;
			mask_r    <= 5'h00;
		end
		else if (clk_en)
		begin
			pll_r     <= pll_nxt;
			filt_r    <= filt_nxt;
			hs_en_r   <= hs_en_nxt;
			jack_db_r <= jack_db_nxt;
			btn_db_r  <= btn_db_nxt;
			mask_r    <= mask_nxt;
		end
	end

	// ==========================================================
	// Debouncers: stable for CSFH_DB_SAMPLES ticks before update, except button code 00 which updates at once
	logic       jack_tick, btn_tick;
	logic [6:0] jack_win, btn_win;
	logic [1:0] hs_type_r, hs_type_nxt;
	logic [1:0] hs_seen_r, hs_seen_nxt;
	logic [3:0] jack_cnt_r, jack_cnt_nxt;
	logic       btn_st_r, btn_st_nxt;
	logic       btn_raw_r, btn_raw_nxt;
	logic [3:0] btn_cnt_r, btn_cnt_nxt;
	logic       btn_press;

	// tick 2 ms shifted by code, 128 ms at codes 6 and 7
	// tick 1 ms shifted by code-1
	// ticks cut from the 1 ms base
	always_comb
	begin
		jack_win = (7'(`CSFH_JACK_BASE_MS) << jack_db_r) - 7'h01;
		btn_win = (7'(`CSFH_BTN_BASE_MS) << (btn_db_r - 2'h1)) - 7'h01;
		jack_tick = ms_tick && ((ms_free_r & jack_win) == jack_win);
		btn_tick = ms_tick && ((ms_free_r & btn_win) == btn_win);
	end

	always_comb
	begin
		hs_type_nxt = hs_type_r;
		hs_seen_nxt = hs_seen_r;
		jack_cnt_nxt = jack_cnt_r;
		btn_st_nxt = btn_st_r;
		btn_raw_nxt = btn_raw_r;
		btn_cnt_nxt = btn_cnt_r;
		btn_press = 1'b0;
		// 00 none, 01 no mic, 11 with mic
		// Next enable used so type reads none right after a disable
		if (!hs_en_nxt)
		begin
			hs_type_nxt = `CSFH_HS_NONE;
			jack_cnt_nxt = 4'h0;
		end
		else if (jack_tick)
		begin
			hs_seen_nxt = {sync2_r[5] & sync2_r[4], sync2_r[4]};
			if (hs_seen_nxt != hs_seen_r)
				jack_cnt_nxt = 4'h0;
			else if (jack_cnt_r == 4'(`CSFH_DB_SAMPLES - 1))
				hs_type_nxt = hs_seen_r;
			else
				jack_cnt_nxt = jack_cnt_r + 4'h1;
		end
		if (!hs_en_nxt)
		begin
			btn_st_nxt = 1'b0;
			btn_cnt_nxt = 4'h0;
		end
		else if (btn_db_r == 2'h0)
		begin
			btn_st_nxt = sync2_r[6];
			btn_press = sync2_r[6] & ~btn_st_r;
		end
		else if (btn_tick)
		begin
			// Sample held tick to tick, so a short press restarts the window
			btn_raw_nxt = sync2_r[6];
			if (sync2_r[6] != btn_raw_r)
				btn_cnt_nxt = 4'h0;
			else if (btn_cnt_r == 4'(`CSFH_DB_SAMPLES - 1))
			begin
				btn_st_nxt = btn_raw_r;
				btn_press = btn_raw_r & ~btn_st_r;
			end
			else
				btn_cnt_nxt = btn_cnt_r + 4'h1;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			hs_type_r  <= 2'h0;
			hs_seen_r  <= 2'h0;
			jack_cnt_r <= 4'h0;
			btn_st_r   <= 1'b0;
			btn_raw_r  <= 1'b0;
			btn_cnt_r  <= 4'h0;
		end
		else if (clk_en)
		begin
			hs_type_r  <= hs_type_nxt;
			hs_seen_r  <= hs_seen_nxt;
			jack_cnt_r <= jack_cnt_nxt;
			btn_st_r   <= btn_st_nxt;
			btn_raw_r  <= btn_raw_nxt;
			btn_cnt_r  <= btn_cnt_nxt;
		end
	end

	// ==========================================================
	// Sticky flags, interrupt status, read port
	logic [3:0] ovf_r, ovf_nxt;
	logic       bflag_r, bflag_nxt;
	logic [4:0] ist_r, ist_nxt;
	logic [7:0] rdata_nxt;
	logic [4:0] ev;

	always_comb
	begin
		ev = {btn_press, sync2_r[3:0]};
		rdata_nxt = 8'h00;
		ovf_nxt = ovf_r;
		bflag_nxt = bflag_r;
		ist_nxt = ist_r;
		if (reg_rd)
		begin
			unique case (reg_addr)
				`CSFH_OFS_OVF_PLL:
				begin
					rdata_nxt = {ovf_r, pll_r};
					// clear only bits read as one
					ovf_nxt = 4'h0;
				end
				`CSFH_OFS_FILT:  rdata_nxt = filt_r;
				`CSFH_OFS_HSDET: rdata_nxt = {hs_en_r, hs_type_r, jack_db_r, btn_db_r};
				`CSFH_OFS_BTN:
				begin
					rdata_nxt[`CSFH_BIT_BTN_FLAG] = bflag_r;
					rdata_nxt[`CSFH_BIT_HS_FLAG] = hs_type_r[0];
					bflag_nxt = 1'b0;
				end
				`CSFH_OFS_IRQ_STAT: rdata_nxt = {3'h0, ist_r};
				`CSFH_OFS_IRQ_MASK: rdata_nxt = {3'h0, mask_r};
				default: rdata_nxt = 8'h00;
			endcase
		end
		if (reg_wr && reg_addr == `CSFH_OFS_IRQ_STAT)
			ist_nxt = ist_r & ~reg_wdata[4:0];
		ovf_nxt = ovf_nxt | {ev[`CSFH_BIT_OVF_ADC_L - 7], ev[`CSFH_BIT_OVF_ADC_R - 5],
			ev[`CSFH_BIT_OVF_DAC_L - 3], ev[`CSFH_BIT_OVF_DAC_R - 1]};
		bflag_nxt = bflag_nxt | btn_press;
		ist_nxt = ist_nxt | ev;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			ovf_r     <= 4'h0;
			bflag_r   <= 1'b0;
			ist_r     <= 5'h00;
			reg_rdata <= 8'h00;
			irq       <= 1'b0;
		end
		else if (clk_en)
		begin
			ovf_r     <= ovf_nxt;
			bflag_r   <= bflag_nxt;
			ist_r     <= ist_nxt;
			reg_rdata <= rdata_nxt;
			irq       <= |(ist_nxt & mask_nxt);
		end
	end

	// ==========================================================
	// Registered control outputs to the datapaths
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			pll_div     <= `CSFH_RST_PLL;
			pll_ratio   <= 5'h01;
			hpf_sel_l   <= 2'h0;
			hpf_sel_r   <= 2'h0;
			eff_en_l    <= 1'b0;
			deemph_en_l <= 1'b0;
			eff_en_r    <= 1'b0;
			deemph_en_r <= 1'b0;
			hsdet_en    <= 1'b0;
		end
		else if (clk_en)
		begin
			pll_div     <= pll_nxt;
			pll_ratio   <= (pll_nxt == 4'h0) ? 5'h10 : {1'b0, pll_nxt};
			hpf_sel_l   <= filt_nxt[7:6];
			hpf_sel_r   <= filt_nxt[5:4];
			eff_en_l    <= filt_nxt[3];
			deemph_en_l <= filt_nxt[2];
			eff_en_r    <= filt_nxt[1];
			deemph_en_r <= filt_nxt[0];
			hsdet_en    <= hs_en_nxt;
		end
	end

endmodule
`default_nettype wire

// [test/csfh_regs_assertions.sv]
// Purpose: Port-level checks for csfh_regs
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to every csfh_regs instance
`timescale 1ns/10ps
`default_nettype none
module csfh_regs_assertions (
	input wire logic       clk_sys,
	input wire logic       rstn,
	input wire logic       clk_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       sat_adc_l,
	input wire logic       sat_adc_r,
	input wire logic       sat_dac_l,
	input wire logic       sat_dac_r,
	input wire logic       jack_in,
	input wire logic       jack_mic,
	input wire logic       button_in,
	input wire logic [3:0] pll_div,
	input wire logic [4:0] pll_ratio,
	input wire logic [1:0] hpf_sel_l,
	input wire logic [1:0] hpf_sel_r,
	input wire logic       eff_en_l,
	input wire logic       deemph_en_l,
	input wire logic       eff_en_r,
	input wire logic       deemph_en_r,
	input wire logic       hsdet_en,
	input wire logic       irq
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	// ==========================================================
	// Qualified strobes
	wire       rd_c = clk_en && reg_rd;
	wire       wr_c = clk_en && reg_wr;
	wire [7:0] filt = {hpf_sel_l, hpf_sel_r, eff_en_l, deemph_en_l, eff_en_r, deemph_en_r};
	a_pll_ratio_map: assert property (pll_ratio == ((pll_div == 4'h0) ? 5'h10 : {1'b0, pll_div}))
		else $error("pll ratio wrong");
	a_pll_wr_data: assert property (wr_c && reg_addr == 8'h0b |=> pll_div == $past(reg_wdata[3:0]))
		else $error("pll write lost");
	a_filt_wr_data: assert property (wr_c && reg_addr == 8'h0c |=> filt == $past(reg_wdata))
		else $error("filter write lost");
	a_hsen_wr_data: assert property (wr_c && reg_addr == 8'h0d |=> hsdet_en == $past(reg_wdata[7]))
		else $error("enable write lost");
	a_ctrl_hold: assert property (clk_en && !reg_wr |=> $stable({pll_div, filt, hsdet_en}))
		else $error("control moved");
	a_rd_pll_val: assert property (rd_c && reg_addr == 8'h0b |=> reg_rdata[3:0] == pll_div)
		else $error("pll readback wrong");
	a_ovf_seen: assert property (sat_adc_l [*4] ##0 (rd_c && reg_addr == 8'h0b) |=> reg_rdata[7])
		else $error("overflow missed");
	a_hs_off_type: assert property (rd_c && reg_addr == 8'h0d && !hsdet_en |=> reg_rdata[7:5] == 3'h0)
		else $error("type while off");
	// Unmapped reads give zero
	a_unmapped_zero: assert property (rd_c && reg_addr > 8'h11 |=> reg_rdata == 8'h00)
		else $error("unmapped data");
endmodule
bind csfh_regs csfh_regs_assertions u_chk (.clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .sat_adc_l(sat_adc_l), .sat_adc_r(sat_adc_r), .sat_dac_l(sat_dac_l),
	.sat_dac_r(sat_dac_r), .jack_in(jack_in), .jack_mic(jack_mic), .button_in(button_in),
	.pll_div(pll_div), .pll_ratio(pll_ratio), .hpf_sel_l(hpf_sel_l), .hpf_sel_r(hpf_sel_r),
	.eff_en_l(eff_en_l), .deemph_en_l(deemph_en_l), .eff_en_r(eff_en_r),
	.deemph_en_r(deemph_en_r), .hsdet_en(hsdet_en), .irq(irq));
`default_nettype wire

// [test/csfh_regs_bench.sv]
// Purpose: Self-checking bench for csfh_regs
// Assumes: 1 ms shortened to 10 cycles
// Notes:   Filter data random from a fixed seed
`timescale 1ns/10ps
`default_nettype none
`include "csfh_consts.svh"
`define CHK(g, e) \
	begin checks++; if ((g) !== (e)) begin n_errors++; \
	$display("wrong value t=%0t got %h exp %h", $time, g, e); end end
module csfh_regs_bench;
	localparam int MS = 10;
	logic       clk_sys = 0;
	logic       rstn = 0;
	logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, d, v;
	logic       reg_wr = 0, reg_rd = 0, jack_in = 0, jack_mic = 0, button_in = 0;
	logic       clk_en = 1;
	logic [3:0] sat = 0, pll_div;
	logic [4:0] pll_ratio, k;
	logic [1:0] hl, hr;
	logic       el, dl, er, dr, hsen, irq;
	int         n_errors = 0, checks = 0, seed = 32'hce03, w;
	// Device under test, clock enable driven by the bench
	csfh_regs #(.MS_CYCLES(MS)) DUT (.clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .sat_adc_l(sat[0]), .sat_adc_r(sat[1]), .sat_dac_l(sat[2]),
		.sat_dac_r(sat[3]), .jack_in(jack_in), .jack_mic(jack_mic), .button_in(button_in),
		.pll_div(pll_div), .pll_ratio(pll_ratio), .hpf_sel_l(hl), .hpf_sel_r(hr),
		.eff_en_l(el), .deemph_en_l(dl), .eff_en_r(er), .deemph_en_r(dr),
		.hsdet_en(hsen), .irq(irq));
	// ==========================================================
	// Bus and helper tasks
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] x);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= x;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		#1;
	endtask
	// Read data stands one cycle only, so it is taken right then
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
	function automatic logic [4:0] ratio(input logic [3:0] c);
		ratio = (c == 4'h0) ? 5'h10 : {1'b0, c};
	endfunction
	task automatic summarize;
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
		begin
			$display("*** PASS ***");
		end
		else
		begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Bounded wait on the interrupt level
	task automatic wait_irq(input logic x);
		for (int i = 0; i < 50 && irq !== x; i++)
			@(posedge clk_sys) #1;
		`CHK(irq, x)
		if (irq !== x)
			summarize();
	endtask
	// ==========================================================
	// Clock and main sequence
	initial forever #5 clk_sys = ~clk_sys;
	initial
	begin
		cyc(20);
		rstn <= 1'b1;
		rd(`CSFH_OFS_OVF_PLL);
		`CHK(d, 8'h01)
		rd(`CSFH_OFS_FILT);
		`CHK(d, 8'h00)
		rd(`CSFH_OFS_HSDET);
		`CHK(d, 8'h00)
		for (k = 0; k < 16; k++)
		begin
			wr(`CSFH_OFS_OVF_PLL, {4'h0, k[3:0]});
			`CHK(pll_ratio, ratio(k[3:0]))
			`CHK(pll_div, k[3:0])
		end
		for (k = 0; k < 10; k++)
		begin
			v = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : 8'($random(seed));
			wr(`CSFH_OFS_FILT, v);
			`CHK({hl, hr, el, dl, er, dr}, v)
			rd(`CSFH_OFS_FILT);
			`CHK(d, v)
		end
		// Low clock enable drops a write
		cyc(1);
		clk_en <= 1'b0;
		wr(`CSFH_OFS_FILT, ~v);
		clk_en <= 1'b1;
		`CHK({hl, hr, el, dl, er, dr}, v)
		rd(`CSFH_OFS_FILT);
		`CHK(d, v)
		// short overflow per channel, sticky then cleared
		for (k = 0; k < 4; k++)
		begin
			cyc(1);
			sat <= 4'h1 << k;
			cyc(2);
			sat <= 4'h0;
			cyc(6);
			rd(`CSFH_OFS_OVF_PLL);
			`CHK(d[7:4], 4'h8 >> k)
			rd(`CSFH_OFS_OVF_PLL);
			`CHK(d[7:4], 4'h0)
		end
		// level held across reads is not lost
		cyc(1);
		sat <= 4'h1;
		cyc(5);
		rd(`CSFH_OFS_OVF_PLL);
		rd(`CSFH_OFS_OVF_PLL);
		`CHK(d[7], 1'b1)
		// Interrupt raise, mask and clear
		wr(`CSFH_OFS_IRQ_MASK, 8'h01);
		cyc(1);
		sat <= 4'h0;
		cyc(5);
		wr(`CSFH_OFS_IRQ_STAT, 8'h1f);
		wait_irq(1'b0);
		cyc(1);
		sat <= 4'h1;
		cyc(1);
		sat <= 4'h0;
		wait_irq(1'b1);
		wr(`CSFH_OFS_IRQ_MASK, 8'h00);
		wait_irq(1'b0);
		wr(`CSFH_OFS_IRQ_MASK, 8'h1f);
		wait_irq(1'b1);
		wr(`CSFH_OFS_IRQ_STAT, 8'h01);
		wait_irq(1'b0);
		// only legal jack codes are written
		jack_in <= 1'b1;
		jack_mic <= 1'b1;
		wr(`CSFH_OFS_HSDET, 8'h80);
		`CHK(hsen, 1'b1)
		cyc(25 * MS);
		rd(`CSFH_OFS_HSDET);
		`CHK(d[6:5], 2'b11)
		jack_mic <= 1'b0;
		cyc(25 * MS);
		rd(`CSFH_OFS_HSDET);
		`CHK(d[6:5], 2'b01)
		// window 32 ms at code 001, then 512 ms at 101
		wr(`CSFH_OFS_HSDET, 8'h84);
		jack_in <= 1'b0;
		cyc(20 * MS);
		rd(`CSFH_OFS_HSDET);
		`CHK(d[6:5], 2'b01)
		cyc(30 * MS);
		rd(`CSFH_OFS_HSDET);
		`CHK(d[6:5], 2'b00)
		wr(`CSFH_OFS_HSDET, 8'h94);
		jack_in <= 1'b1;
		cyc(400 * MS);
		rd(`CSFH_OFS_HSDET);
		`CHK(d, 8'h94)
		cyc(250 * MS);
		rd(`CSFH_OFS_HSDET);
		`CHK(d[6:5], 2'b01)
		// immediate press at code 00, flag clears on read
		wr(`CSFH_OFS_HSDET, 8'h80);
		rd(`CSFH_OFS_BTN);
		button_in <= 1'b1;
		cyc(3);
		button_in <= 1'b0;
		cyc(6);
		rd(`CSFH_OFS_BTN);
		`CHK(d[5], 1'b1)
		rd(`CSFH_OFS_BTN);
		`CHK(d[5], 1'b0)
		// half window filtered, long press caught
		for (k = 1; k < 4; k++)
		begin
			w = (8 * MS) << (k - 1);
			wr(`CSFH_OFS_HSDET, 8'h80 | k[1:0]);
			rd(`CSFH_OFS_BTN);
			button_in <= 1'b1;
			cyc(w / 2);
			button_in <= 1'b0;
			cyc(w * 2);
			rd(`CSFH_OFS_BTN);
			`CHK(d[5], 1'b0)
			button_in <= 1'b1;
			cyc(w * 2);
			button_in <= 1'b0;
			cyc(w * 2);
			rd(`CSFH_OFS_BTN);
			`CHK(d[5], 1'b1)
		end
		// detection off forces type to none
		wr(`CSFH_OFS_HSDET, 8'h00);
		`CHK(hsen, 1'b0)
		rd(`CSFH_OFS_HSDET);
		`CHK(d, 8'h00)
		// Unmapped place ignores writes
		wr(8'h3f, 8'hff);
		rd(8'h3f);
		`CHK(d, 8'h00)
		summarize();
	end
endmodule
`default_nettype wire
